// >>> rtl/aac_acq_ctrl.sv
// register file and conversion sequencer for the analog acquisition path
`timescale 1ns/100ps
module aac_acq_ctrl
  import aac_pkg::*;
#(
  parameter int RES_W = 12,
  parameter int NCH = 4,
  parameter int NQ = 8
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  output logic [7:0] sfr_rdata_o,
  output logic [2:0] conv_input_select_o,
  output logic [3:0] input_buffer_enables_o,
  output logic [2:0] test_output_select_o,
  output logic opamp_power_on_o,
  output logic pot_switch_power_on_o,
  output logic current_level_select_o,
  output logic current_output_on_o,
  output logic test_output_on_o,
  output logic converter_power_on_o,
  output logic gain_amp_power_on_o,
  output logic reference_power_on_o,
  output logic ext_ref_cap_size_o,
  output logic conv_clk_o,
  output logic conv_start_o,
  output logic [2:0] conv_chan_o,
  input wire logic conv_done_i,
  input wire logic [RES_W-1:0] conv_data_i,
  output logic cal_start_o,
  input wire logic cal_done_i,
  output logic cal_force_o,
  output logic [4*NQ-1:0] cal_vector_o,
  output logic [3:0] cal_table_address_o,
  input wire logic [3:0] cal_table_data_i,
  input wire logic [7:0] otp_bandgap_i,
  input wire logic [7:0] otp_gain_i,
  input wire logic gain_lsb_i,
  output logic [7:0] bandgap_trim_o,
  output logic [8:0] gain_amp_trim_o,
  output logic conv_irq_o
);

  // software-visible state
  logic [7:0] pwr_reg;
  logic [7:0] div_reg;
  logic [7:0] bgap_reg;
  logic [7:0] gain_reg;
  logic [6:0] inmux_reg;
  logic [2:0] outmux_reg;
  logic [23:0] rate_reg;
  logic cap_reg;
  logic skip_reg;
  logic ie_reg;
  logic one_reg;
  logic continuous_mode_reg;
  logic flag_reg;
  logic flag_next;
  logic pend_reg;
  logic force_reg;
  logic [2:0] qidx_reg;
  logic [3:0] quart_reg [NQ];
  logic [3:0] caddr_reg;
  logic [RES_W-1:0] res_reg [NCH];
  logic [7:0] rdata_reg;
  // sequencer state
  aac_state_t st_reg;
  logic [1:0] idx_reg;
  logic start_reg;
  logic calgo_reg;
  logic [2:0] chan_reg;
  logic pass_done;
  // timers
  logic [23:0] rcnt_reg;
  logic [8:0] dcnt_reg;
  logic cclk_reg;
  // synchronisers for the analog handshakes
  logic done_s1, done_s2, done_s3;
  logic cal_s1, cal_s2, cal_s3;
  // result word staged beside the done flag; it stays steady while done is high
  logic [RES_W-1:0] data_s1, data_s2;

  // write strobes, all frozen while the enable is low
  wire wr_en = ce_i & sfr_wr_i;
  wire wr_pwr = wr_en && (sfr_addr_i == A_PWR);
  wire wr_cdiv = wr_en && (sfr_addr_i == A_CDIV);
  wire wr_ctrl = wr_en && (sfr_addr_i == A_CTRL);
  wire wr_rlo = wr_en && (sfr_addr_i == A_RLO);
  wire wr_rmd = wr_en && (sfr_addr_i == A_RMD);
  wire wr_rhi = wr_en && (sfr_addr_i == A_RHI);
  wire wr_force = wr_en && (sfr_addr_i == A_FORCE);
  wire wr_ctab = wr_en && (sfr_addr_i == A_CTAB);
  wire wr_bgap = wr_en && (sfr_addr_i == A_BGAP);
  wire wr_gain = wr_en && (sfr_addr_i == A_GAIN);
  wire wr_inmux = wr_en && (sfr_addr_i == A_INMUX);
  wire wr_outmux = wr_en && (sfr_addr_i == A_OUTMUX);

  // converter power gates every pass and the reference clock
  wire adc_on = pwr_reg[P_ADC];
  wire [2:0] insel = inmux_reg[INSEL_HI:INSEL_LO];
  // last conversion of a pass
  wire last_ch = one_reg || (idx_reg == 2'(NCH - 1));
  // one-channel results always land in slot zero
  wire [1:0] slot = one_reg ? 2'h0 : idx_reg;
  wire done_rise = done_s2 & ~done_s3;
  wire cal_rise = cal_s2 & ~cal_s3;
  // continuous interval is rate value plus one clocks
  wire rate_tick = continuous_mode_reg && adc_on && (rcnt_reg >= rate_reg);
  wire go = (st_reg == ST_IDLE) && pend_reg && adc_on;
  // flag events: hardware or software set, software clear
  wire flag_set = pass_done | (wr_ctrl & sfr_wdata_i[C_FLAG]);
  wire flag_clr = wr_ctrl & sfr_wdata_i[C_CLR];

  // register read decode, shared by the data register below
  function automatic logic [7:0] rd_mux(input logic [7:0] a);
    logic [7:0] v;
    v = RST_VAL;
    unique case (a)
      A_PWR: v = pwr_reg;
      A_CDIV: v = div_reg;
      // clear bit reads zero; trigger bit shows a pending pass
      A_CTRL: v = {1'b0, cap_reg, skip_reg, flag_reg, ie_reg, one_reg, continuous_mode_reg, pend_reg};
      A_RLO: v = rate_reg[7:0];
      A_RMD: v = rate_reg[15:8];
      A_RHI: v = rate_reg[23:16];
      // quartet number is write only and reads zero
      A_FORCE: v = {force_reg, 3'h0, quart_reg[qidx_reg]};
      A_CTAB: v = {cal_table_data_i, 4'h0};
      A_BGAP: v = bgap_reg;
      A_GAIN: v = gain_reg;
      A_INMUX: v = {1'b0, inmux_reg};
      A_OUTMUX: v = {5'h00, outmux_reg};
      default: v = RST_VAL;
    endcase
    // result bytes: low byte, then upper nibble in 3:0
    for (int i = 0; i < NCH; i++) begin
      if (a == A_RES_LO[i]) begin
        v = res_reg[i][7:0];
      end
      if (a == A_RES_HI[i]) begin
        v = {4'h0, res_reg[i][RES_W-1:8]};
      end
    end
    return v;
  endfunction

  // flag: a set in the same cycle as a clear wins
  assign flag_next = flag_set ? 1'b1 : (flag_clr ? 1'b0 : flag_reg);

  // analog power and trim registers
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pwr_reg <= RST_VAL;
      div_reg <= RST_VAL;
      // factory trims come back from otp at every reset
      bgap_reg <= otp_bandgap_i;
      gain_reg <= otp_gain_i;
    end else begin
      if (wr_pwr) begin
        pwr_reg <= sfr_wdata_i;
      end
      if (wr_cdiv) begin
        div_reg <= sfr_wdata_i;
      end
      if (wr_bgap) begin
        bgap_reg <= sfr_wdata_i;
      end
      if (wr_gain) begin
        gain_reg <= sfr_wdata_i;
      end
    end
  end

  // multiplexer and rate registers
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      inmux_reg <= 7'h00;
      outmux_reg <= 3'h0;
      rate_reg <= 24'h000000;
    end else begin
      if (wr_inmux) begin
        inmux_reg <= sfr_wdata_i[INSEL_HI:0];
      end
      if (wr_outmux) begin
        outmux_reg <= sfr_wdata_i[OSEL_HI:0];
      end
      if (wr_rlo) begin
        rate_reg[7:0] <= sfr_wdata_i;
      end
      if (wr_rmd) begin
        rate_reg[15:8] <= sfr_wdata_i;
      end
      if (wr_rhi) begin
        rate_reg[23:16] <= sfr_wdata_i;
      end
    end
  end

  // converter control bits and the interrupt flag
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cap_reg <= 1'b0;
      skip_reg <= 1'b0;
      ie_reg <= 1'b0;
      one_reg <= 1'b0;
      continuous_mode_reg <= 1'b0;
      flag_reg <= 1'b0;
    end else if (ce_i) begin
      flag_reg <= flag_next;
      if (wr_ctrl) begin
        cap_reg <= sfr_wdata_i[C_CAP];
        skip_reg <= sfr_wdata_i[C_SKIP];
        ie_reg <= sfr_wdata_i[C_IE];
        one_reg <= sfr_wdata_i[C_ONE];
        continuous_mode_reg <= sfr_wdata_i[C_CONTINUOUS_MODE];
      end
    end
  end

  // pending pass request: a new request beats the start
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pend_reg <= 1'b0;
    end else if (ce_i) begin
      if ((wr_ctrl && sfr_wdata_i[C_SHOT]) || rate_tick) begin
        pend_reg <= 1'b1;
      end else if (go) begin
        pend_reg <= 1'b0;
      end
    end
  end

  // calibration quartets and table address
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      force_reg <= 1'b0;
      qidx_reg <= 3'h0;
      caddr_reg <= 4'h0;
      for (int q = 0; q < NQ; q++) begin
        quart_reg[q] <= 4'h0;
      end
    end else if (wr_force) begin
      force_reg <= sfr_wdata_i[F_FORCE];
      qidx_reg <= sfr_wdata_i[Q_HI:Q_LO];
      quart_reg[sfr_wdata_i[Q_HI:Q_LO]] <= sfr_wdata_i[NIB_HI:0];
    end else if (wr_ctab) begin
      caddr_reg <= sfr_wdata_i[NIB_HI:0];
    end
  end

  // quartets side by side form the forced vector
  for (genvar g = 0; g < NQ; g++) begin : g_vec
    assign cal_vector_o[4*g+3:4*g] = quart_reg[g];
  end

  // two-flop synchronisers; edges are taken from stage two on
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      {done_s1, done_s2, done_s3} <= 3'h0;
      {cal_s1, cal_s2, cal_s3} <= 3'h0;
      data_s1 <= '0;
      data_s2 <= '0;
    end else if (ce_i) begin
      {done_s1, done_s2, done_s3} <= {conv_done_i, done_s1, done_s2};
      {cal_s1, cal_s2, cal_s3} <= {cal_done_i, cal_s1, cal_s2};
      // the word is only used once the done edge has passed both stages
      data_s1 <= conv_data_i;
      data_s2 <= data_s1;
    end
  end

  // continuous-mode interval counter
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rcnt_reg <= 24'h000000;
    end else if (ce_i) begin
      if (!continuous_mode_reg || !adc_on || rate_tick) begin
        rcnt_reg <= 24'h000000;
      end else begin
        rcnt_reg <= rcnt_reg + 24'h000001;
      end
    end
  end

  // reference clock: half period of 2*(div+1) clocks
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      dcnt_reg <= 9'h000;
      cclk_reg <= 1'b0;
    end else if (ce_i) begin
      if (!adc_on) begin
        dcnt_reg <= 9'h000;
        cclk_reg <= 1'b0;
      end else if (dcnt_reg == {div_reg, 1'b1}) begin
        dcnt_reg <= 9'h000;
        cclk_reg <= ~cclk_reg;
      end else begin
        dcnt_reg <= dcnt_reg + 9'h001;
      end
    end
  end

  // pass sequencer: optional calibration, then one or four conversions
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st_reg <= ST_IDLE;
      idx_reg <= 2'h0;
      start_reg <= 1'b0;
      calgo_reg <= 1'b0;
      chan_reg <= 3'h0;
      pass_done <= 1'b0;
    end else if (ce_i) begin
      start_reg <= 1'b0;
      calgo_reg <= 1'b0;
      pass_done <= 1'b0;
      if (!adc_on) begin
        // power loss aborts a pass without raising the flag
        st_reg <= ST_IDLE;
      end else begin
        unique case (st_reg)
          ST_IDLE: begin
            if (go) begin
              idx_reg <= 2'h0;
              calgo_reg <= ~skip_reg;
              st_reg <= skip_reg ? ST_CONV : ST_CAL;
            end
          end
          ST_CAL: begin
            if (cal_rise) begin
              st_reg <= ST_CONV;
            end
          end
          ST_CONV: begin
            start_reg <= 1'b1;
            chan_reg <= one_reg ? insel : {1'b0, idx_reg};
            st_reg <= ST_WAIT;
          end
          ST_WAIT: begin
            if (done_rise && last_ch) begin
              pass_done <= 1'b1;
              st_reg <= ST_IDLE;
            end else if (done_rise) begin
              idx_reg <= idx_reg + 2'h1;
              st_reg <= ST_CONV;
            end
          end
        endcase
      end
    end
  end

  // result store, straight binary code as the core returns it
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      for (int i = 0; i < NCH; i++) begin
        res_reg[i] <= '0;
      end
    end else if (ce_i && (st_reg == ST_WAIT) && done_rise && adc_on) begin
      res_reg[slot] <= data_s2;
    end
  end

  // read data is taken on the read strobe and held
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rdata_reg <= RST_VAL;
    end else if (ce_i && sfr_rd_i) begin
      rdata_reg <= rd_mux(sfr_addr_i);
    end
  end

  // outputs toward the analog front end
  assign sfr_rdata_o = rdata_reg;
  assign conv_input_select_o = insel;
  assign input_buffer_enables_o = inmux_reg[AIN_HI:0];
  assign test_output_select_o = outmux_reg;
  assign opamp_power_on_o = pwr_reg[P_OPAMP];
  assign pot_switch_power_on_o = pwr_reg[P_POT];
  assign current_level_select_o = pwr_reg[P_ILVL];
  assign current_output_on_o = pwr_reg[P_IOUT];
  assign test_output_on_o = pwr_reg[P_TEST];
  assign converter_power_on_o = adc_on;
  assign gain_amp_power_on_o = pwr_reg[P_GAIN];
  assign reference_power_on_o = pwr_reg[P_BGAP];
  assign ext_ref_cap_size_o = cap_reg;
  assign conv_clk_o = cclk_reg;
  assign conv_start_o = start_reg;
  assign conv_chan_o = chan_reg;
  assign cal_start_o = calgo_reg;
  assign cal_force_o = force_reg;
  assign cal_table_address_o = caddr_reg;
  assign bandgap_trim_o = bgap_reg;
  // gain trim lsb lives in a separate register outside this block
  assign gain_amp_trim_o = {gain_reg, gain_lsb_i};
  assign conv_irq_o = flag_reg & ie_reg;

  // checks on the block's own behaviour
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i || !ce_i);

  sequence s_store;
    (st_reg == ST_WAIT) && done_rise && adc_on;
  endsequence

  a_clear_drops_flag: assert property ((flag_clr && !flag_set) |=> !flag_reg)
    else $error("flag not cleared");
  a_set_raises_flag: assert property ((wr_ctrl && sfr_wdata_i[C_FLAG]) |=> flag_reg && conv_irq_o == ie_reg)
    else $error("software set lost");
  a_pass_end_flag: assert property (pass_done |=> flag_reg && (!ie_reg || conv_irq_o))
    else $error("pass end did not flag");
  a_irq_masked: assert property ((wr_ctrl && !sfr_wdata_i[C_IE]) |=> !conv_irq_o)
    else $error("irq not masked");
  a_one_slot_zero: assert property ((s_store ##0 one_reg) |=> res_reg[0] == $past(data_s2))
    else $error("single result not in slot zero");
  a_one_chan_sel: assert property ((conv_start_o && one_reg) |-> conv_chan_o == insel)
    else $error("wrong single channel");
  a_shot_starts: assert property ((go && skip_reg) |-> ##2 conv_start_o)
    else $error("single pass did not start");
  a_cal_before: assert property ((go && !skip_reg) |=> cal_start_o ##1 (st_reg == ST_CAL))
    else $error("calibration skipped");
  a_rate_restart: assert property (rate_tick |=> rcnt_reg == 24'h000000 && pend_reg)
    else $error("rate tick lost");
endmodule

// >>> rtl/aac_pkg.sv
// shared constants and types for the analog acquisition control block
package aac_pkg;
  // register addresses
  localparam logic [7:0] A_PWR = 8'h92;
  localparam logic [7:0] A_CDIV = 8'h95;
  localparam logic [7:0] A_CTRL = 8'hA2;
  localparam logic [7:0] A_RLO = 8'hA3;
  localparam logic [7:0] A_RMD = 8'hA4;
  localparam logic [7:0] A_RHI = 8'hA5;
  localparam logic [7:0] A_RES_LO [4] = '{8'hA6, 8'hA9, 8'hAB, 8'hAD};
  localparam logic [7:0] A_RES_HI [4] = '{8'hA7, 8'hAA, 8'hAC, 8'hAE};
  localparam logic [7:0] A_FORCE = 8'hB1;
  localparam logic [7:0] A_CTAB = 8'hB2;
  localparam logic [7:0] A_BGAP = 8'hB3;
  localparam logic [7:0] A_GAIN = 8'hB4;
  localparam logic [7:0] A_INMUX = 8'hB5;
  localparam logic [7:0] A_OUTMUX = 8'hB6;
  // converter control bits
  localparam int C_CLR = 7;
  localparam int C_CAP = 6;
  localparam int C_SKIP = 5;
  localparam int C_FLAG = 4;
  localparam int C_IE = 3;
  localparam int C_ONE = 2;
  localparam int C_CONTINUOUS_MODE = 1;
  localparam int C_SHOT = 0;
  // power enable bits
  localparam int P_OPAMP = 7;
  localparam int P_POT = 6;
  localparam int P_ILVL = 5;
  localparam int P_IOUT = 4;
  localparam int P_TEST = 3;
  localparam int P_ADC = 2;
  localparam int P_GAIN = 1;
  localparam int P_BGAP = 0;
  // field positions
  localparam int INSEL_HI = 6;
  localparam int INSEL_LO = 4;
  localparam int AIN_HI = 3;
  localparam int OSEL_HI = 2;
  localparam int F_FORCE = 7;
  localparam int Q_HI = 6;
  localparam int Q_LO = 4;
  localparam int NIB_HI = 3;
  localparam int TDAT_LO = 4;
  localparam logic [7:0] RST_VAL = 8'h00;
  // sequencer states
  typedef enum logic [1:0] {ST_IDLE, ST_CAL, ST_CONV, ST_WAIT} aac_state_t;
endpackage

// >>> tb/aac_core_model.sv
// behavioural analog core that answers conversion and calibration requests
`timescale 1ns/100ps
module aac_core_model (
  input wire logic clk_i,
  input wire logic conv_start_i,
  input wire logic [2:0] conv_chan_i,
  input wire logic cal_start_i,
  input wire logic [3:0] tab_addr_i,
  input wire logic [11:0] base_i,
  output logic conv_done_o,
  output logic [11:0] conv_data_o,
  output logic cal_done_o,
  output logic [3:0] tab_data_o,
  output int cal_cnt_o
);
  // table content is a fixed function of the address, same clock domain
  assign tab_data_o = ~tab_addr_i;
  // conversion: random latency, straight binary code per channel
  initial begin
    conv_done_o = 1'b0;
    conv_data_o = 12'h000;
    forever begin
      @(posedge clk_i);
      if (conv_start_i === 1'b1) begin
        repeat ($urandom_range(8, 2)) @(posedge clk_i);
        conv_data_o <= base_i + 12'(conv_chan_i) * 12'h111;
        @(posedge clk_i);
        conv_done_o <= 1'b1;
        // data held four clocks past the done edge; done drops early enough
        // that the next start of a four-channel pass is not missed
        repeat (4) @(posedge clk_i);
        conv_done_o <= 1'b0;
        conv_data_o <= ~conv_data_o; // stale data must not be reused
      end
    end
  end
  // calibration: counted so the bench can tell whether it ran
  initial begin
    cal_done_o = 1'b0;
    cal_cnt_o = 0;
    forever begin
      @(posedge clk_i);
      if (cal_start_i === 1'b1) begin
        cal_cnt_o <= cal_cnt_o + 1;
        repeat ($urandom_range(12, 3)) @(posedge clk_i);
        cal_done_o <= 1'b1;
        repeat (4) @(posedge clk_i);
        cal_done_o <= 1'b0;
      end
    end
  end
endmodule

// >>> tb/test_analog_acquisition_control.sv
// self-checking bench for the acquisition register file and sequencer
`timescale 1ns/100ps
module test_analog_acquisition_control;
  import aac_pkg::*;
  logic clk_i, srst_i, ce_i, sfr_wr_i, sfr_rd_i, gain_lsb_i, rd_seen;
  logic [7:0] sfr_addr_i, sfr_wdata_i, otp_bg, otp_gn, me, mm, ma, d;
  logic [7:0] v [8];
  logic [11:0] base, e;
  logic [31:0] vec;
  logic [2:0] s;
  int n_errors, tests_run, i, k, t0, c0, cal_cnt, div;
  logic prev;
  logic [7:0] exp_q [$]; // expected read data, oldest first
  logic [7:0] msk_q [$]; // bits that are defined for that read
  logic [7:0] adr_q [$];
  wire [7:0] sfr_rdata_o, bandgap_trim_o, pwr_w;
  wire [2:0] conv_input_select_o, test_output_select_o, conv_chan_o;
  wire [3:0] input_buffer_enables_o, cal_table_address_o, cal_table_data_i;
  wire [8:0] gain_amp_trim_o;
  wire [31:0] cal_vector_o;
  wire [11:0] conv_data_i;
  wire ext_ref_cap_size_o, conv_clk_o, conv_start_o, conv_done_i, cal_start_o;
  wire cal_done_i, cal_force_o, conv_irq_o;
  // readable-write registers and the bits they return
  logic [7:0] rw_a [8] = '{A_CDIV, A_RLO, A_RMD, A_RHI, A_BGAP, A_GAIN, A_INMUX, A_OUTMUX};
  logic [7:0] rw_m [8] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h7F, 8'h07};

  aac_acq_ctrl DUT (.clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i), .sfr_addr_i(sfr_addr_i),
    .sfr_wdata_i(sfr_wdata_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i), .sfr_rdata_o(sfr_rdata_o),
    .conv_input_select_o(conv_input_select_o), .input_buffer_enables_o(input_buffer_enables_o),
    .test_output_select_o(test_output_select_o), .opamp_power_on_o(pwr_w[7]),
    .pot_switch_power_on_o(pwr_w[6]), .current_level_select_o(pwr_w[5]), .current_output_on_o(pwr_w[4]),
    .test_output_on_o(pwr_w[3]), .converter_power_on_o(pwr_w[2]), .gain_amp_power_on_o(pwr_w[1]),
    .reference_power_on_o(pwr_w[0]), .ext_ref_cap_size_o(ext_ref_cap_size_o), .conv_clk_o(conv_clk_o),
    .conv_start_o(conv_start_o), .conv_chan_o(conv_chan_o), .conv_done_i(conv_done_i),
    .conv_data_i(conv_data_i), .cal_start_o(cal_start_o), .cal_done_i(cal_done_i),
    .cal_force_o(cal_force_o), .cal_vector_o(cal_vector_o), .cal_table_address_o(cal_table_address_o),
    .cal_table_data_i(cal_table_data_i), .otp_bandgap_i(otp_bg), .otp_gain_i(otp_gn),
    .gain_lsb_i(gain_lsb_i), .bandgap_trim_o(bandgap_trim_o), .gain_amp_trim_o(gain_amp_trim_o),
    .conv_irq_o(conv_irq_o));

  aac_core_model core (.clk_i(clk_i), .conv_start_i(conv_start_o), .conv_chan_i(conv_chan_o),
    .cal_start_i(cal_start_o), .tab_addr_i(cal_table_address_o), .base_i(base),
    .conv_done_o(conv_done_i), .conv_data_o(conv_data_i), .cal_done_o(cal_done_i),
    .tab_data_o(cal_table_data_i), .cal_cnt_o(cal_cnt));

  // 40 MHz system clock
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  task automatic tally_and_finish();
    if (n_errors == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    tests_run++;
    if (got !== ex) begin
      n_errors++;
      $display("FAIL %s exp %h got %h", nm, ex, got);
    end
  endtask

  // a bound that ran out ends the run
  task automatic hang(input string nm);
    n_errors++;
    $display("FAIL %s exp done got timeout", nm);
    tally_and_finish();
  endtask

  // one write strobe; returns at the falling edge so outputs have settled
  task automatic wr(input logic [7:0] a, input logic [7:0] dt);
    @(posedge clk_i);
    sfr_addr_i <= a;
    sfr_wdata_i <= dt;
    sfr_wr_i <= 1'b1;
    @(posedge clk_i);
    sfr_wr_i <= 1'b0;
    @(negedge clk_i);
  endtask

  // one read strobe; the expectation is queued for the monitor
  task automatic rd(input logic [7:0] a, input logic [7:0] ex, input logic [7:0] m);
    @(posedge clk_i);
    sfr_addr_i <= a;
    sfr_rd_i <= 1'b1;
    exp_q.push_back(ex);
    msk_q.push_back(m);
    adr_q.push_back(a);
    @(posedge clk_i);
    sfr_rd_i <= 1'b0;
  endtask

  task automatic wait_irq();
    for (k = 0; k < 3000 && conv_irq_o !== 1'b1; k++) @(negedge clk_i);
    if (conv_irq_o !== 1'b1) hang("conv_irq");
  endtask

  // read data shows right after the taking edge; compare the oldest note at the next falling edge
  always @(posedge clk_i) rd_seen <= sfr_rd_i & ce_i;
  always @(negedge clk_i) begin
    if (rd_seen === 1'b1) begin
      me = exp_q.pop_front();
      mm = msk_q.pop_front();
      ma = adr_q.pop_front();
      tests_run++;
      if ((sfr_rdata_o & mm) !== (me & mm)) begin
        n_errors++;
        $display("FAIL read %h exp %h got %h", ma, me & mm, sfr_rdata_o & mm);
      end
    end
  end

  initial begin
    n_errors = 0;
    tests_run = 0;
    i = $urandom(4);
    {srst_i, ce_i, sfr_wr_i, sfr_rd_i} = 4'b1100;
    sfr_addr_i = 8'h00;
    sfr_wdata_i = 8'h00;
    base = 12'h000;
    otp_bg = 8'($urandom);
    otp_gn = 8'($urandom);
    gain_lsb_i = 1'($urandom);
    repeat (8) @(posedge clk_i);
    srst_i <= 1'b0;
    @(negedge clk_i);
    // values after reset, trims loaded from factory memory
    chk("conv_clk off", 0, conv_clk_o);
    chk("gain trim", {otp_gn, gain_lsb_i}, gain_amp_trim_o);
    for (i = 0; i < 8; i++) rd(rw_a[i], (i == 4) ? otp_bg : (i == 5) ? otp_gn : 8'h00, 8'hFF);
    for (i = 0; i < 4; i++) rd(A_RES_LO[i], 8'h00, 8'hFF);
    rd(A_CTRL, 8'h00, 8'hFF);
    wr(8'hA8, 8'hFF);
    rd(8'hA8, 8'h00, 8'hFF);
    // random write and read back, undefined bits return zero
    for (i = 0; i < 8; i++) begin
      v[i] = 8'($urandom);
      wr(rw_a[i], v[i]);
      rd(rw_a[i], v[i] & rw_m[i], 8'hFF);
    end
    chk("input select", v[6][6:4], conv_input_select_o);
    chk("buffer enables", v[6][3:0], input_buffer_enables_o);
    chk("test select", v[7][2:0], test_output_select_o);
    chk("bandgap trim", v[4], bandgap_trim_o);
    chk("gain trim", {v[5], gain_lsb_i}, gain_amp_trim_o);
    // each power bit alone reaches its own output
    for (i = 0; i < 8; i++) begin
      wr(A_PWR, 8'h01 << i);
      chk("power bits", 8'h01 << i, pwr_w);
      rd(A_PWR, 8'h01 << i, 8'hFF);
    end
    // a write while the clock enable is low is lost
    @(posedge clk_i);
    ce_i <= 1'b0;
    wr(A_CDIV, ~v[0]);
    @(posedge clk_i);
    ce_i <= 1'b1;
    rd(A_CDIV, v[0], 8'hFF);
    // converter clock period is 4 times divider plus one
    div = $urandom_range(3, 0);
    wr(A_CDIV, 8'(div));
    wr(A_PWR, 8'h04);
    k = 0;
    prev = conv_clk_o;
    for (i = 0; i < 200 && k < 2; i++) begin
      @(negedge clk_i);
      if (conv_clk_o === 1'b1 && prev === 1'b0) begin
        k++;
        if (k == 2) chk("conv_clk period", 4 * (div + 1), i - t0);
        t0 = i;
      end
      prev = conv_clk_o;
    end
    if (k < 2) hang("conv_clk");
    // one-channel single pass, calibration skipped, result of input s in slot 0
    s = 3'($urandom);
    wr(A_INMUX, {1'b0, s, 4'hF});
    base = 12'($urandom);
    c0 = cal_cnt;
    wr(A_CTRL, 8'h2D);
    wait_irq();
    e = base + 12'(s) * 12'h111;
    rd(A_RES_LO[0], e[7:0], 8'hFF);
    rd(A_RES_HI[0], {4'h0, e[11:8]}, 8'hFF);
    rd(A_RES_LO[2], 8'h00, 8'hFF);
    rd(A_CTRL, 8'h3C, 8'hFE);
    chk("no calibration", c0, cal_cnt);
    wr(A_CTRL, 8'hA8);
    chk("irq cleared", 0, conv_irq_o);
    rd(A_CTRL, 8'h28, 8'hFE);
    // four-channel pass with calibration first
    base = 12'($urandom);
    c0 = cal_cnt;
    wr(A_CTRL, 8'h09);
    wait_irq();
    chk("calibration ran", c0 + 1, cal_cnt);
    for (i = 0; i < 4; i++) begin
      e = base + 12'(i) * 12'h111;
      rd(A_RES_LO[i], e[7:0], 8'hFF);
      rd(A_RES_HI[i], {4'h0, e[11:8]}, 8'hFF);
    end
    // continuous one-channel passes every 65 clocks; the flag comes back after a clear
    wr(A_RLO, 8'h40);
    wr(A_RMD, 8'h00);
    wr(A_RHI, 8'h00);
    base = 12'($urandom);
    wr(A_CTRL, 8'hAE);
    wait_irq();
    wr(A_CTRL, 8'hAE);
    chk("continuous_mode irq cleared", 0, conv_irq_o);
    wait_irq();
    // stop in one-channel mode so a pass still pending lands in slot zero
    wr(A_CTRL, 8'h24);
    repeat (60) @(negedge clk_i);
    e = base + 12'(s) * 12'h111;
    rd(A_RES_LO[0], e[7:0], 8'hFF);
    rd(A_CTRL, 8'h34, 8'hFE);
    // software set wins over clear; request gated by enable
    wr(A_CTRL, 8'h90);
    chk("irq masked", 0, conv_irq_o);
    rd(A_CTRL, 8'h10, 8'hFE);
    wr(A_CTRL, 8'h18);
    chk("irq enabled", 1, conv_irq_o);
    wr(A_CTRL, 8'hC0);
    chk("cap size", 1, ext_ref_cap_size_o);
    rd(A_CTRL, 8'h40, 8'hFE);
    // quartets build the calibration vector
    vec = 32'h0;
    for (i = 0; i < 8; i++) begin
      d = 8'($urandom) & 8'h0F;
      vec[4*i +: 4] = d[3:0];
      wr(A_FORCE, {1'b1, 3'(i), d[3:0]});
      rd(A_FORCE, {4'h8, d[3:0]}, 8'hFF);
    end
    chk("cal vector", vec, cal_vector_o);
    chk("cal force", 1, cal_force_o);
    // table port: address out, data back in the upper nibble
    for (i = 0; i < 4; i++) begin
      d = 8'($urandom);
      wr(A_CTAB, d);
      chk("table address", d[3:0], cal_table_address_o);
      rd(A_CTAB, {~d[3:0], 4'h0}, 8'hF0);
    end
    repeat (4) @(posedge clk_i);
    tally_and_finish();
  end
endmodule
